// >>> hdl/ealm_map.svh
// Register map, field positions, reset values and timing figures of the
// eight-line asynchronous multiplexer. Definitions only; APB byte addresses.
// Function
// - Sixteen selectable rates, 50 to 19,200 bps
// - Top rate code really runs at 19,800 bps
// - Lines 0 and 1 split speed, modem control
// - Shared 48-entry receive queue with line, status
// - Receive alarm above 16 or after timeout
// - 32-character transmit buffer, one or two per write
// - DMA fills buffer, pauses, refills below two
// - DMA done and buffer empty raises transmit event
// - Auto flow: XOFF stops transmitter, still queued
// - Auto flow: XON restarts transmitter, still queued
// - Reset or master reset empties buffers, disables lines
// - Master reset clears stored modem bits, not pins
// - Disabled line marks unless echo selected
// - Transmit ready on buffer empty, after DMA done in DMA mode
// - Transmit interrupt when ready sets while enabled
// - Line number field names the finished line
// - DMA abort sets error flag with ready
// - CSR read clears ready; no new set before
// - Buffer count readable; load, flush any time
// - Disable stops after current character, resumes later
// - No receive DMA; each read pops oldest
// - Data-available flag follows queue non-empty
// - DMA aborts after 32 us without answer
`ifndef EALM_MAP_SVH
`define EALM_MAP_SVH
`define EALM_CLK_HZ 100000000
`define EALM_OFS_CSR 8'h00
`define EALM_OFS_LPR 8'h04
`define EALM_OFS_RBUF 8'h08
`define EALM_OFS_RXTMO 8'h0c
`define EALM_OFS_LINE_EN 8'h10
`define EALM_OFS_TXDATA 8'h14
`define EALM_OFS_MODEM 8'h18
`define EALM_OFS_DMA_ADR 8'h1c
`define EALM_OFS_DMA_CNT 8'h20
`define EALM_CSR_MRST 5
`define EALM_CSR_RIE 6
`define EALM_CSR_TIE 14
`define EALM_TXD_TWO 16
`define EALM_TXD_FLUSH 17
`define EALM_RST_VAL 32'h0000_0000
`define EALM_RX_DEPTH 48
`define EALM_TX_DEPTH 32
`define EALM_RX_ALARM 16
`define EALM_DMA_TMO_NS 32000
`define EALM_TMO_UNIT_NS 1000
`define EALM_XOFF 8'h13
`define EALM_XON 8'h11
// Real line rates in hundredths of bps, code 15 first
`define EALM_BAUD_CBPS {32'd1980000, 32'd960000, 32'd720000, 32'd480000, \
  32'd360000, 32'd240000, 32'd200506, 32'd180000, 32'd120000, 32'd60000, \
  32'd30000, 32'd15000, 32'd13452, 32'd11000, 32'd7500, 32'd5000}
`endif

// >>> hdl/ealm_pkg.sv
// Types shared by the multiplexer and whoever connects to it.
// Assumes ealm_map.svh supplies all numbers.
package ealm_pkg;
  typedef enum logic [1:0] {dma_idle = 2'b01, dma_wait = 2'b10} ealm_dma_st_t;
  typedef struct packed {
    logic valid;
    logic ovr;
    logic ferr;
    logic perr;
    logic rsvd;
    logic [2:0] line;
    logic [7:0] ch;
  } ealm_rxent_t;
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } ealm_mem_req_t;
endpackage

// >>> hdl/ealm_mux.sv
// Eight-line asynchronous multiplexer: APB slave, per-line UARTs,
// transmit buffers, DMA refill engine and shared receive queue.
// Assumes pins and memory answers synchronous to clk.
`include "ealm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module ealm_mux import ealm_pkg::*; #(
  parameter int TX_DEPTH = `EALM_TX_DEPTH,
  parameter int RX_DEPTH = `EALM_RX_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rxd,
  output logic [7:0] txd,
  input wire logic [1:0] modem_in,
  output logic [1:0] modem_out,
  output ealm_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic rx_irq,
  output logic tx_irq
);
  localparam int TW = $clog2(TX_DEPTH);
  localparam int RW = $clog2(RX_DEPTH + 1);
  localparam int MHZ = `EALM_CLK_HZ / 1000000;
  localparam int DMA_TMO = `EALM_DMA_TMO_NS * MHZ / 1000;
  localparam int US_CYC = `EALM_TMO_UNIT_NS * MHZ / 1000;

  if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0 || RX_DEPTH <= `EALM_RX_ALARM
      || DMA_TMO > 4095) begin : g_chk
    $error("ealm_mux: unsupported depth or timeout");
  end

  typedef struct packed {
    logic [4:0] idx;
    logic rie;
    logic tie;
    logic rdy;
    logic derr;
    logic mrst;
    logic [2:0] tline;
    logic [7:0][15:0] lpar;
    logic [7:0] ten;
    logic [7:0] ren;
    logic [7:0] afc;
    logic [7:0] dmam;
    logic [7:0] echo;
    logic [7:0] xoff;
    logic [7:0] pend;
    logic [7:0] perr;
    logic [7:0] fill;
    logic [7:0] tbusy;
    logic [7:0] rbusy;
    logic [7:0] rhold;
    logic [7:0] txd;
    logic [1:0] msw;
    logic [1:0] mpin;
    logic [7:0] tmo;
    logic [7:0][TX_DEPTH-1:0][7:0] tbuf;
    logic [7:0][TW-1:0] trd;
    logic [7:0][TW:0] tcnt;
    logic [7:0][15:0] dcnt;
    logic [7:0][15:0] dadr;
    ealm_dma_st_t dst;
    logic [2:0] dline;
    logic [11:0] dtmr;
    logic [7:0][11:0] tsh;
    logic [7:0][3:0] tbits;
    logic [7:0][20:0] tdiv;
    logic [7:0][20:0] rdiv;
    logic [7:0][3:0] ridx;
    logic [7:0][9:0] rsh;
    ealm_rxent_t [7:0] rent;
    ealm_rxent_t [RX_DEPTH-1:0] rq;
    logic [RW-1:0] rqn;
    logic [6:0] upre;
    logic [7:0] ucnt;
    logic [31:0] rdat;
  } ealm_st_t;

  function automatic ealm_st_t st_init();
    st_init = '0;
    st_init.dst = dma_idle;
    st_init.txd = 8'hff;
  endfunction
  localparam ealm_st_t ST0 = st_init();

  // Code 15 divides for 19,800 bps
  function automatic logic [20:0] bit_per(input logic [3:0] c);
    logic [511:0] tab;
    logic [31:0] r;
    longint q;
    tab = `EALM_BAUD_CBPS;
    r = tab[{c, 5'h00} +: 32];
    q = longint'(`EALM_CLK_HZ) * 100 / longint'(r);
    bit_per = q[20:0];
  endfunction

  ealm_st_t s;
  ealm_st_t n;
  logic setup;
  logic acc;
  logic mapped;
  logic alarm;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign mapped = paddr <= `EALM_OFS_DMA_CNT && paddr[1:0] == 2'b00;
  assign alarm = s.rqn != '0 && s.ucnt >= s.tmo;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = s.rdat;
  assign txd = s.txd;
  assign modem_out = s.mpin;
  assign mem_req.req = s.dst == dma_wait;
  assign mem_req.addr = s.dadr[s.dline];
  assign rx_irq = s.rie & ((s.rqn > RW'(`EALM_RX_ALARM)) | alarm);
  assign tx_irq = s.tie & s.rdy;

  always_comb begin
    logic [2:0] sel;
    logic [2:0] pv;
    logic [2:0][2:0] pl;
    logic [2:0][7:0] pc;
    logic [11:0] f;
    logic [7:0] c;
    logic [20:0] per;
    logic pe;
    logic pb;
    logic pop;
    logic found;
    int len;
    int nb;
    sel = s.idx[2:0];
    pv = '0;
    pl = '0;
    pc = '0;
    f = '0;
    c = '0;
    per = '0;
    pe = 1'b0;
    pb = 1'b0;
    pop = 1'b0;
    found = 1'b0;
    len = 0;
    nb = 0;
    n = s;
    // Read data captured in setup so prdata comes from a flop
    if (setup) begin
      unique case (paddr)
        `EALM_OFS_CSR: n.rdat = {16'h0000, s.rdy, s.tie, 1'b0, s.derr, 1'b0, s.tline,
                                 s.rqn != '0, s.rie, s.mrst, s.idx};
        `EALM_OFS_LPR: n.rdat = {16'h0000, s.lpar[sel]};
        `EALM_OFS_RBUF: n.rdat = {16'h0000, (s.rqn != '0) ? s.rq[0] : ealm_rxent_t'(16'h0000)};
        `EALM_OFS_RXTMO: n.rdat = {24'h000000, s.tmo};
        `EALM_OFS_LINE_EN: n.rdat = {s.dmam, s.afc, s.ren, s.ten};
        `EALM_OFS_TXDATA: n.rdat = 32'(s.tcnt[sel]);
        `EALM_OFS_MODEM: n.rdat = {16'h0000, s.echo, 2'b00, modem_in, 2'b00, s.msw};
        `EALM_OFS_DMA_ADR: n.rdat = {16'h0000, s.dadr[sel]};
        `EALM_OFS_DMA_CNT: n.rdat = {16'h0000, s.dcnt[sel]};
        default: n.rdat = `EALM_RST_VAL;
      endcase
    end
    // Read clears ready and its fields
    if (acc && !pwrite && paddr == `EALM_OFS_CSR) begin
      n.rdy = 1'b0;
      n.tline = 3'h0;
      n.derr = 1'b0;
    end
    if (acc && !pwrite && paddr == `EALM_OFS_RBUF && s.rqn != '0) begin
      pop = 1'b1;
      for (int k = 0; k < RX_DEPTH - 1; k++) begin
        n.rq[k] = s.rq[k + 1];
      end
      n.rq[RX_DEPTH - 1] = '0;
      n.rqn = s.rqn - RW'(1);
    end
    // One held character per cycle into the queue
    for (int i = 0; i < 8; i++) begin
      if (s.rhold[i] && !found) begin
        found = 1'b1;
        n.rhold[i] = 1'b0;
        if (n.rqn < RW'(RX_DEPTH)) begin
          n.rq[n.rqn] = s.rent[i];
          n.rqn = n.rqn + RW'(1);
        end
      end
    end
    // Alarm timer restarts on each read
    if (pop || s.rqn == '0) begin
      n.upre = '0;
      n.ucnt = '0;
    end else if (s.upre == 7'(US_CYC - 1)) begin
      n.upre = '0;
      n.ucnt = (s.ucnt == 8'hff) ? s.ucnt : s.ucnt + 8'h01;
    end else begin
      n.upre = s.upre + 7'h01;
    end
    for (int i = 0; i < 8; i++) begin
      pe = s.lpar[i][5];
      len = int'(s.lpar[i][4:3]) + 5;
      // Split receive rate on lines 0 and 1 only
      per = bit_per((i < 2) ? s.lpar[i][11:8] : s.lpar[i][15:12]);
      if (!s.rbusy[i]) begin
        if (s.ren[i] && !rxd[i]) begin
          n.rbusy[i] = 1'b1;
          n.rdiv[i] = per >> 1;
          n.ridx[i] = 4'h0;
        end
      end else if (s.rdiv[i] != '0) begin
        n.rdiv[i] = s.rdiv[i] - 21'h1;
      end else begin
        n.rdiv[i] = per - 21'h1;
        if (s.ridx[i] == 4'h0) begin
          n.rbusy[i] = ~rxd[i];
          n.ridx[i] = 4'h1;
        end else if (int'(s.ridx[i]) == len + int'(pe) + 1) begin
          n.rbusy[i] = 1'b0;
          c = s.rsh[i][7:0] & (8'hff >> (8 - len));
          pb = s.rsh[i][len];
          n.rent[i] = '{valid: 1'b1, ovr: n.rhold[i], ferr: ~rxd[i],
                        perr: pe & ((^c ^ pb) == s.lpar[i][6]), rsvd: 1'b0,
                        line: 3'(i), ch: c};
          n.rhold[i] = 1'b1;
          if (s.afc[i] && c == `EALM_XOFF) begin
            n.xoff[i] = 1'b1;
          end
          if (s.afc[i] && c == `EALM_XON) begin
            n.xoff[i] = 1'b0;
          end
        end else begin
          n.rsh[i][s.ridx[i] - 4'h1] = rxd[i];
          n.ridx[i] = s.ridx[i] + 4'h1;
        end
      end
      // Transmitter
      per = bit_per(s.lpar[i][15:12]);
      if (s.tbusy[i]) begin
        if (s.tdiv[i] != '0) begin
          n.tdiv[i] = s.tdiv[i] - 21'h1;
        end else if (s.tbits[i] == 4'h1) begin
          n.tbusy[i] = 1'b0;
        end else begin
          n.tsh[i] = {1'b1, s.tsh[i][11:1]};
          n.tbits[i] = s.tbits[i] - 4'h1;
          n.tdiv[i] = per - 21'h1;
        end
      end else if (s.ten[i] && !s.xoff[i] && s.tcnt[i] != '0) begin
        c = s.tbuf[i][s.trd[i]] & (8'hff >> (8 - len));
        f = 12'hfff;
        f[0] = 1'b0;
        for (int b = 0; b < 8; b++) begin
          if (b < len) begin
            f[b + 1] = c[b];
          end
        end
        if (pe) begin
          f[len + 1] = ^c ^ ~s.lpar[i][6];
        end
        nb = len + int'(pe) + 2 + int'(s.lpar[i][7]);
        n.tsh[i] = f;
        n.tbits[i] = 4'(nb);
        n.tdiv[i] = per - 21'h1;
        n.tbusy[i] = 1'b1;
        n.trd[i] = s.trd[i] + TW'(1);
        n.tcnt[i] = s.tcnt[i] - (TW + 1)'(1);
        // DMA mode needs count at zero too
        if (s.tcnt[i] == (TW + 1)'(1) && (!s.dmam[i] || s.dcnt[i] == '0)) begin
          n.pend[i] = 1'b1;
        end
      end
      n.txd[i] = s.echo[i] ? rxd[i] : (n.tbusy[i] ? n.tsh[i][0] : 1'b1);
    end
    unique case (s.dst)
      dma_idle: begin
        found = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (!found && s.dmam[i] && s.fill[i] && s.dcnt[i] != '0
              && s.tcnt[i] < (TW + 1)'(TX_DEPTH)) begin
            found = 1'b1;
            n.dst = dma_wait;
            n.dline = 3'(i);
            n.dtmr = '0;
          end
        end
      end
      dma_wait: begin
        if (mem_ack) begin
          pv[0] = 1'b1;
          pl[0] = s.dline;
          pc[0] = mem_rdata;
          n.dadr[s.dline] = s.dadr[s.dline] + 16'h0001;
          n.dcnt[s.dline] = s.dcnt[s.dline] - 16'h0001;
          n.dst = dma_idle;
        end else if (s.dtmr == 12'(DMA_TMO - 1)) begin
          n.dcnt[s.dline] = '0;
          n.pend[s.dline] = 1'b1;
          n.perr[s.dline] = 1'b1;
          n.dst = dma_idle;
        end else begin
          n.dtmr = s.dtmr + 12'h001;
        end
      end
      // Two of four codes are unused; recover to idle
      default: n.dst = dma_idle;
    endcase
    if (acc && pwrite) begin
      unique case (paddr)
        `EALM_OFS_CSR: begin
          n.idx = pwdata[4:0];
          n.mrst = s.mrst | pwdata[`EALM_CSR_MRST];
          n.rie = pwdata[`EALM_CSR_RIE];
          n.tie = pwdata[`EALM_CSR_TIE];
        end
        `EALM_OFS_LPR: n.lpar[pwdata[2:0]] = pwdata[15:0];
        `EALM_OFS_RXTMO: n.tmo = pwdata[7:0];
        `EALM_OFS_LINE_EN: {n.dmam, n.afc, n.ren, n.ten} = pwdata;
        // One or two characters per write
        // Load or flush regardless of enable
        `EALM_OFS_TXDATA: begin
          if (pwdata[`EALM_TXD_FLUSH]) begin
            n.tcnt[sel] = '0;
          end else begin
            pv[1] = 1'b1;
            pl[1] = sel;
            pc[1] = pwdata[7:0];
            pv[2] = pwdata[`EALM_TXD_TWO];
            pl[2] = sel;
            pc[2] = pwdata[15:8];
          end
        end
        `EALM_OFS_MODEM: begin
          n.msw = pwdata[1:0];
          n.mpin = pwdata[1:0];
          n.echo = pwdata[15:8];
        end
        `EALM_OFS_DMA_ADR: n.dadr[sel] = pwdata[15:0];
        `EALM_OFS_DMA_CNT: begin
          n.dcnt[sel] = pwdata[15:0];
          n.fill[sel] = 1'b1;
        end
        default: n.idx = s.idx;
      endcase
    end
    for (int k = 0; k < 3; k++) begin
      if (pv[k] && n.tcnt[pl[k]] < (TW + 1)'(TX_DEPTH)) begin
        n.tbuf[pl[k]][TW'(n.trd[pl[k]] + n.tcnt[pl[k]][TW-1:0])] = pc[k];
        n.tcnt[pl[k]] = n.tcnt[pl[k]] + (TW + 1)'(1);
      end
    end
    // Pause when full, resume below two
    for (int i = 0; i < 8; i++) begin
      if (n.tcnt[i] == (TW + 1)'(TX_DEPTH)) begin
        n.fill[i] = 1'b0;
      end else if (n.tcnt[i] < (TW + 1)'(2)) begin
        n.fill[i] = 1'b1;
      end
    end
    // Line field names the finished line
    // Blocked during any CSR access so a read never loses a set
    found = 1'b0;
    if (!s.rdy && !(psel && paddr == `EALM_OFS_CSR)) begin
      for (int i = 0; i < 8; i++) begin
        if (s.pend[i] && !found) begin
          found = 1'b1;
          n.rdy = 1'b1;
          n.tline = 3'(i);
          n.derr = s.perr[i];
          n.pend[i] = 1'b0;
          n.perr[i] = 1'b0;
        end
      end
    end
    // Master reset empties and disables all
    // Modem pins kept across master reset
    if (s.mrst) begin
      n = ST0;
      n.mpin = s.mpin;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= ST0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  rda_flag_a: assert property (setup && paddr == `EALM_OFS_CSR |=>
    prdata[7] == ($past(s.rqn) != '0)) else $error("data-available flag wrong");
  rx_count_a: assert property (s.rie && s.rqn > RW'(`EALM_RX_ALARM) |-> rx_irq)
    else $error("receive alarm missing");
  rdy_clear_a: assert property (acc && !pwrite && paddr == `EALM_OFS_CSR |=> !s.rdy)
    else $error("ready not cleared by read");
  rdy_hold_a: assert property (s.rdy && !(acc && !pwrite && paddr == `EALM_OFS_CSR)
    && !s.mrst |=> s.rdy && $stable(s.tline)) else $error("ready or line changed");
  tx_int_a: assert property ($rose(s.rdy) && s.tie |-> tx_irq)
    else $error("transmit interrupt missing");
  xoff_stop_a: assert property (s.afc[0] && s.xoff[0] && !s.tbusy[0] |=>
    !s.tbusy[0]) else $error("transmitter started under XOFF");
  mark_idle_a: assert property (((~s.tbusy & ~$past(s.echo) & ~s.txd)) == 8'h00)
    else $error("idle line not marking");
  dma_abort_a: assert property (s.dst == dma_wait && s.dtmr == 12'(DMA_TMO - 1) && !mem_ack
    && !s.mrst |=> s.perr[$past(s.dline)] && s.dcnt[$past(s.dline)] == '0)
    else $error("DMA timeout not aborted");
  mrst_empty_a: assert property (s.mrst |=> s.rqn == '0 && s.tcnt == '0 && s.ten == '0
    && s.ren == '0) else $error("master reset left state");
  modem_keep_a: assert property (s.mrst |=> s.msw == 2'b00 && $stable(s.mpin))
    else $error("modem pins wrong after master reset");

  rdy_set_c: cover property ($rose(s.rdy));
  rx_tmo_c: cover property (alarm && s.rqn <= RW'(`EALM_RX_ALARM) && s.rie);
  dma_err_c: cover property ($rose(s.derr));
  xoff_c: cover property ($rose(s.xoff[0]));
endmodule
`default_nettype wire

// >>> sim/ealm_far_model.sv
// Far side of the multiplexer: serial terminals on the receive pins and
// a byte memory answering DMA fetches. Assumes the multiplexer's clk.
`timescale 1ns/10ps
`default_nettype none
module ealm_far_model import ealm_pkg::*; (
  input wire logic clk,
  input wire logic stall,
  input wire ealm_mem_req_t mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic [7:0] rxd
);
  logic [1:0] wait_q;
  initial begin
    rxd = 8'hff;
    mem_ack = 1'b0;
    mem_rdata = 8'h5a;
    wait_q = 2'h0;
  end
  // Data bus toggles outside an answer so stale bytes never look valid
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req.req && !stall && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h2) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem_req.addr[7:0];
        wait_q <= 2'h0;
      end
    end
  end
  // Five data bits, no parity, one stop; line idles marking
  task automatic send_char(input logic [2:0] ln, input logic [4:0] ch, input int bt);
    logic [6:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 7; i++) begin
      rxd[ln] <= frame[i];
      repeat (bt) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the eight-line multiplexer over APB.
// Assumes ealm_far_model as the terminals and memory behind the pins.
`include "ealm_map.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench import ealm_pkg::*; ;
  typedef struct {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] x;
    logic e;
  } ealm_row_t;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, mem_ack, rx_irq, tx_irq, stall;
  logic [7:0] paddr, rxd, txd, mem_rdata;
  logic [31:0] pwdata, prdata, rdv;
  logic [1:0] modem_out;
  logic er;
  ealm_mem_req_t mem_req;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;
  ealm_row_t rows [10] = '{
    '{1'b0, `EALM_OFS_CSR, 32'h0, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b0, `EALM_OFS_TXDATA, 32'h0, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b0, `EALM_OFS_RBUF, 32'h0, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b1, `EALM_OFS_RXTMO, 32'h1, 32'h0, 32'h0, 1'b0},
    '{1'b0, `EALM_OFS_RXTMO, 32'h0, 32'hff, 32'h1, 1'b0},
    '{1'b1, `EALM_OFS_MODEM, 32'h3, 32'h0, 32'h0, 1'b0},
    '{1'b0, `EALM_OFS_MODEM, 32'h0, 32'h33, 32'h23, 1'b0},
    '{1'b0, 8'h24, 32'h0, 32'hffff_ffff, 32'h0, 1'b1},
    '{1'b1, 8'h28, 32'hffff_ffff, 32'h0, 32'h0, 1'b1},
    '{1'b0, 8'h02, 32'h0, 32'hffff_ffff, 32'h0, 1'b1}
  };

  ealm_mux dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .modem_in(2'b10), .modem_out(modem_out), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_irq(rx_irq), .tx_irq(tx_irq));
  ealm_far_model far (.clk(clk), .stall(stall), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Two serial frames dominate the run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle cycle first, so back-to-back calls never drive psel twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(rdv & m, x);
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 1'b1;
    repeat (4) @(posedge clk);
    check({24'h0, txd}, 32'hff);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) check(rdv & rows[i].m, rows[i].x);
      check({31'h0, er}, {31'h0, rows[i].e});
    end
    check({30'h0, modem_out}, 32'h3);
    apb(1'b1, `EALM_OFS_CSR, 32'h3);
    for (int i = 0; i < 17; i++) apb(1'b1, `EALM_OFS_TXDATA, 32'h0001_4241);
    rd_chk(`EALM_OFS_TXDATA, 32'hff, 32'h20);
    check({24'h0, txd}, 32'hff);
    apb(1'b1, `EALM_OFS_CSR, 32'h20);
    rd_chk(`EALM_OFS_CSR, 32'hffff, 32'h0);
    apb(1'b1, `EALM_OFS_CSR, 32'h3);
    rd_chk(`EALM_OFS_TXDATA, 32'hff, 32'h0);
    rd_chk(`EALM_OFS_MODEM, 32'h3, 32'h0);
    check({30'h0, modem_out}, 32'h3);
    apb(1'b1, `EALM_OFS_TXDATA, 32'h41);
    rd_chk(`EALM_OFS_TXDATA, 32'hff, 32'h1);
    apb(1'b1, `EALM_OFS_TXDATA, 32'h0002_0000);
    rd_chk(`EALM_OFS_TXDATA, 32'hff, 32'h0);
    // Memory never answers: fetch must give up
    apb(1'b1, `EALM_OFS_CSR, 32'h4004);
    apb(1'b1, `EALM_OFS_LINE_EN, 32'h1000_0010);
    apb(1'b1, `EALM_OFS_DMA_ADR, 32'h0100);
    apb(1'b1, `EALM_OFS_DMA_CNT, 32'h3);
    k = 0;
    while (mem_req.req !== 1'b1 && k < 20) begin @(posedge clk); k++; end
    check({16'h0, mem_req.addr}, 32'h0100);
    k = 0;
    while (tx_irq !== 1'b1 && k < 4000) begin @(posedge clk); k++; end
    check({31'h0, (k > 3190 && k < 3210)}, 32'h1);
    check({31'h0, tx_irq}, 32'h1);
    rd_chk(`EALM_OFS_CSR, 32'hffff, 32'hd404);
    rd_chk(`EALM_OFS_CSR, 32'hffff, 32'h4004);
    check({31'h0, tx_irq}, 32'h0);
    stall <= 1'b0;
    apb(1'b1, `EALM_OFS_LINE_EN, 32'h1000_0000);
    apb(1'b1, `EALM_OFS_DMA_ADR, 32'h0200);
    apb(1'b1, `EALM_OFS_DMA_CNT, 32'h3);
    k = 0;
    do begin apb(1'b0, `EALM_OFS_TXDATA, 32'h0); k++; end while (rdv[5:0] !== 6'h3 && k < 20);
    check(rdv & 32'hff, 32'h3);
    apb(1'b1, `EALM_OFS_LPR, 32'h0000_f002);
    apb(1'b1, `EALM_OFS_LINE_EN, 32'h1004_0400);
    apb(1'b1, `EALM_OFS_CSR, 32'h0042);
    @(posedge clk);
    far.send_char(3'h2, 5'h13, 5050);
    repeat (300) @(posedge clk);
    check({31'h0, rx_irq}, 32'h1);
    rd_chk(`EALM_OFS_CSR, 32'h80, 32'h80);
    apb(1'b1, `EALM_OFS_LINE_EN, 32'h1004_0404);
    apb(1'b1, `EALM_OFS_TXDATA, 32'h41);
    k = 0;
    repeat (2000) begin @(posedge clk); if (txd[2] !== 1'b1) k++; end
    check(k, 32'h0);
    rd_chk(`EALM_OFS_RBUF, 32'hffff, 32'h8213);
    rd_chk(`EALM_OFS_CSR, 32'h80, 32'h0);
    check({31'h0, rx_irq}, 32'h0);
    far.send_char(3'h2, 5'h11, 5050);
    k = 0;
    while (txd[2] !== 1'b0 && k < 3000) begin @(posedge clk); k++; end
    check({31'h0, txd[2]}, 32'h0);
    rd_chk(`EALM_OFS_RBUF, 32'hffff, 32'h8211);
    rd_chk(`EALM_OFS_CSR, 32'h8700, 32'h8200);
    print_verdict();
  end
endmodule
`default_nettype wire
